/* File: core/dmt_consts.vh */
`ifndef DMT_CONSTS_VH
`define DMT_CONSTS_VH

// register byte offsets, one 32-bit word each
`define DMT_OFS_CTRL0     8'h00
`define DMT_OFS_CNT0      8'h20
`define DMT_OFS_CAPTURE_RELOAD_REGISTER    8'h40
`define DMT_OFS_STATUS    8'h44
`define DMT_NUM_TIMERS    5

// timer indices
`define DMT_AUX_A         0
`define DMT_CORE_ONE      1
`define DMT_AUX_B         2
`define DMT_AUX_C         3
`define DMT_CORE_TWO      4

// control field positions
`define DMT_F_MODE_LO     0
`define DMT_F_MODE_HI     2
`define DMT_F_RUN         3
`define DMT_F_DOWN        4
`define DMT_F_EXT_DIR     5
`define DMT_F_PSC_LO      6
`define DMT_F_PSC_HI      8
`define DMT_F_EDGE_RISE   9
`define DMT_F_EDGE_FALL   10
`define DMT_F_LATCH_TRIG  11
`define DMT_F_LATCH_FALL  12
`define DMT_F_CAP_RELOAD  14
`define DMT_F_CLEAR_CAP   15
`define DMT_F_SRC_CNT     16
`define DMT_F_SRC_DIR     17
`define DMT_CTRL_BITS     18
`define DMT_CTRL_RESET    18'h00000

// modes
`define DMT_MODE_TIMER    3'h0
`define DMT_MODE_GATED    3'h1
`define DMT_MODE_COUNTER  3'h2
`define DMT_MODE_ENCODER  3'h3
`define DMT_MODE_LATCH    3'h4
`define DMT_MODE_RELOAD   3'h5
`define DMT_MODE_CAPTURE  3'h6

// fastest count periods in system clocks
`define DMT_BASE_ONE      10'h004
`define DMT_BASE_TWO      10'h002
`define DMT_PRE_BITS      10

// status flag positions
`define DMT_FLAG_CAPTURE  5

`endif

/* File: core/dmt_timer_unit.v */
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "dmt_consts.vh"

module dmt_timer_unit
(
   input  wire        clk,
   input  wire        rst_n,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   input  wire [4:0]  timer_gate_count_input,
   input  wire [3:0]  timer_direction_input,
   input  wire        capture_trigger_pin,
   output reg         core_one_latch_pin,
   output reg         core_two_latch_pin,
   output reg         core_two_wrap_pulse
);

   // pins: 0..4 gate/count, 5..8 direction (timers 0,1,2,4), 9 capture
   wire [9:0]  pin_raw = {capture_trigger_pin, timer_direction_input, timer_gate_count_input};
   reg  [9:0]  sync1;
   reg  [9:0]  sync2;
   reg  [9:0]  sync3;
   reg  [9:0]  pin_lvl;
   reg  [9:0]  pin_old;
   wire [9:0]  pin_rise = pin_lvl & ~pin_old;
   wire [9:0]  pin_fall = ~pin_lvl & pin_old;

   reg  [`DMT_CTRL_BITS-1:0] ctrl [0:4];
   reg  [15:0] cnt [0:4];
   reg  [15:0] capture_reload_register;
   reg  [5:0]  flags;
   reg  [9:0]  pre_one;
   reg  [9:0]  pre_two;
   reg         core_one_toggle_latch;
   reg         core_two_toggle_latch;
   reg         one_latch_old;
   reg         two_latch_old;
   reg  [4:0]  pend;
   reg  [4:0]  pend_up;

   wire [4:0]  step;
   wire [4:0]  dir_up;
   wire [4:0]  wrap;
   wire [4:0]  ext_ev;
   wire [4:0]  new_ev;
   wire [4:0]  new_up;
   wire [4:0]  reload_req;
   wire [4:0]  capture_req;
   wire [79:0] next_step;

   // stage one may be metastable, so only stage two reads it
   // a level is taken only when two stages agree, so glitches drop
   // synchroniser: a change counts once stages two and three agree
   genvar p;
   generate
      for (p = 0; p < 10; p = p + 1)
      begin : g_sync
         always @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               sync1[p]   <= 1'b0;
               sync2[p]   <= 1'b0;
               sync3[p]   <= 1'b0;
               pin_lvl[p] <= 1'b0;
               pin_old[p] <= 1'b0;
            end
            else
            begin
               sync1[p] <= pin_raw[p];
               sync2[p] <= sync1[p];
               sync3[p] <= sync2[p];
               if (sync2[p] == sync3[p])
                  pin_lvl[p] <= sync3[p];
               pin_old[p] <= pin_lvl[p];
            end
         end
      end
   endgenerate

   // they clock latch-mode aux timers and trigger latch reloads
   // latch transitions, seen one cycle after the toggle
   wire one_rise = core_one_toggle_latch & ~one_latch_old;
   wire one_fall = ~core_one_toggle_latch & one_latch_old;
   wire two_rise = core_two_toggle_latch & ~two_latch_old;
   wire two_fall = ~core_two_toggle_latch & two_latch_old;

   // module two has no gated or encoder mode
   // pin events wait in pend until the next fastest tick
   // per-timer count decision
   genvar i;
   generate
      for (i = 0; i < 5; i = i + 1)
      begin : g_tmr
         localparam         MOD2 = (i >= 3);
         localparam integer DI   = (i == 4) ? 8 : 5 + i;
         wire [2:0] mode   = ctrl[i][`DMT_F_MODE_HI:`DMT_F_MODE_LO];
         wire       run    = ctrl[i][`DMT_F_RUN];
         wire [2:0] psc    = ctrl[i][`DMT_F_PSC_HI:`DMT_F_PSC_LO];
         wire       e_rise = ctrl[i][`DMT_F_EDGE_RISE];
         wire       e_fall = ctrl[i][`DMT_F_EDGE_FALL];
         wire [9:0] pre    = MOD2 ? pre_two : pre_one;
         wire [9:0] base   = MOD2 ? `DMT_BASE_TWO : `DMT_BASE_ONE;
         // each prescale step doubles the base period
         wire [9:0] mask   = (base << psc) - 10'h001;
         // prescaled tick and fastest permitted tick
         wire       ptick  = (pre & mask) == 10'h000;
         wire       ftick  = (pre & (base - 10'h001)) == 10'h000;
         // aux c has no direction pin
         wire       dpin   = (i == 3) ? 1'b0 : pin_lvl[DI];
         wire       dold   = (i == 3) ? 1'b0 : pin_old[DI];
         wire       a_ev   = pin_lvl[i] ^ pin_old[i];
         wire       b_ev   = (i == 3) ? 1'b0 : dpin ^ dold;
         wire       lr     = MOD2 ? two_rise : one_rise;
         wire       lf     = MOD2 ? two_fall : one_fall;
         // gate active high, low when falling edge bit set
         wire       gate   = pin_lvl[i] ^ e_fall;
         wire       sw_up  = ctrl[i][`DMT_F_EXT_DIR] ? ~dpin : ~ctrl[i][`DMT_F_DOWN];
         wire       enc    = (mode == `DMT_MODE_ENCODER) && !MOD2;

         assign ext_ev[i] = (pin_rise[i] & e_rise) | (pin_fall[i] & e_fall);
         // events queued and released at the fastest rate
         // latch mode counts chosen transitions of its own core latch
         assign new_ev[i] = run && (
                  (mode == `DMT_MODE_COUNTER && ext_ev[i]) ||
                  (enc && (a_ev || b_ev)) ||
                  (mode == `DMT_MODE_LATCH && i != 1 && i != 4 &&
                   ((lr && e_rise) || (lf && e_fall))));
         // every edge of both tracks counts, four per encoder line
         // quadrature: A edge up when A differs from B, B edge up when equal
         assign new_up[i] = enc ? (a_ev ? (pin_lvl[i] != dpin) : (pin_lvl[i] == dpin)) : sw_up;
         assign dir_up[i] = (pend[i] && ftick) ? pend_up[i] : sw_up;
         // capture and reload roles stop the timer
         // roles never step, so the stored value holds
         assign step[i] = run && ((mode == `DMT_MODE_TIMER && ptick) ||
                  (mode == `DMT_MODE_GATED && !MOD2 && ptick && gate) ||
                  (pend[i] && ftick));
         assign next_step[i*16 +: 16] = dir_up[i] ? cnt[i] + 16'h0001 : cnt[i] - 16'h0001;
         // wrap on the step that leaves the end value
         assign wrap[i] = step[i] && (dir_up[i] ? cnt[i] == 16'hffff : cnt[i] == 16'h0000);
         // aux roles for core one
         assign reload_req[i] = mode == `DMT_MODE_RELOAD && (ext_ev[i] ||
                  (ctrl[i][`DMT_F_LATCH_TRIG] && (ctrl[i][`DMT_F_LATCH_FALL] ? one_fall : one_rise)));
         assign capture_req[i] = mode == `DMT_MODE_CAPTURE && ext_ev[i];

         // pending event holder
         // a second event before release merges into the first
         // direction is kept with the event, not read at release
         always @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               pend[i]    <= 1'b0;
               pend_up[i] <= 1'b0;
            end
            else if (new_ev[i])
            begin
               pend[i]    <= 1'b1;
               pend_up[i] <= new_up[i];
            end
            else if (ftick)
               pend[i] <= 1'b0;
         end
      end
   endgenerate

   // capture register trigger selection
   // both source bits clear selects the capture pin
   wire [1:0] cap_src = {ctrl[3][`DMT_F_SRC_DIR], ctrl[3][`DMT_F_SRC_CNT]};
   wire       cap_pin = (pin_rise[9] & ctrl[3][`DMT_F_EDGE_RISE]) | (pin_fall[9] & ctrl[3][`DMT_F_EDGE_FALL]);
   wire       cap_hit = (cap_src == 2'b00) ? cap_pin :
                        ((cap_src[0] & (pin_rise[1] | pin_fall[1])) |
                         (cap_src[1] & (pin_rise[6] | pin_fall[6])));

   // bus decode
   // every address is acked; misaligned or unmapped words read zero
   // writes land at the ack edge, read data is taken at the request
   wire        bus_req  = wb_cyc_i & wb_stb_i;
   wire        bus_wr   = bus_req & wb_we_i & wb_ack_o;
   wire [31:0] wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [2:0]  widx     = wb_adr_i[4:2];
   wire        hit_ctrl = (wb_adr_i[7:5] == 3'h0) && (widx < 3'h5) && (wb_adr_i[1:0] == 2'b00);
   wire        hit_cnt  = (wb_adr_i[7:5] == 3'h1) && (widx < 3'h5) && (wb_adr_i[1:0] == 2'b00);
   wire        hit_cap  = wb_adr_i == `DMT_OFS_CAPTURE_RELOAD_REGISTER;
   wire        hit_stat = wb_adr_i == `DMT_OFS_STATUS;

   reg [31:0] rd_word;
   reg [31:0] ctrl_wr;
   reg [31:0] cnt_wr;
   reg [31:0] cap_wr;

   // read mux and masked write values
   // bits above a field read zero and drop on write
   always @*
   begin
      rd_word = 32'h0000_0000;
      if (hit_ctrl)
         rd_word = {14'h0000, ctrl[widx]};
      else if (hit_cnt)
         rd_word = {16'h0000, cnt[widx]};
      else if (hit_cap)
         rd_word = {16'h0000, capture_reload_register};
      else if (hit_stat)
         rd_word = {26'h0000000, flags};
      ctrl_wr = ({14'h0000, ctrl[widx]} & ~wmask) | (wb_dat_i & wmask);
      cnt_wr  = ({16'h0000, cnt[widx]} & ~wmask) | (wb_dat_i & wmask);
      cap_wr  = ({16'h0000, capture_reload_register} & ~wmask) | (wb_dat_i & wmask);
   end

   // wishbone answer: ack one cycle after request, write at ack edge
   // ack falls for one cycle even if the request stays up
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= bus_req & ~wb_ack_o;
         if (bus_req & ~wb_ack_o)
            wb_dat_o <= rd_word;
      end
   end

   // control registers and prescalers
   // prescalers run free, so the first tick phase is not fixed
   integer k;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (k = 0; k < 5; k = k + 1)
            ctrl[k] <= `DMT_CTRL_RESET;
         pre_one <= 10'h000;
         pre_two <= 10'h000;
      end
      else
      begin
         pre_one <= pre_one + 10'h001;
         pre_two <= pre_two + 10'h001;
         if (bus_wr && hit_ctrl)
            ctrl[widx] <= ctrl_wr[`DMT_CTRL_BITS-1:0];
      end
   end

   // counters, roles and reloads; bus write wins over hardware
   // roles only move counts, control bits stay as written
   integer j;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (j = 0; j < 5; j = j + 1)
            cnt[j] <= 16'h0000;
         capture_reload_register <= 16'h0000;
      end
      else
      begin
         // aux timers of module one: count or capture core one
         for (j = 0; j < 3; j = j + 2)
         begin
            if (bus_wr && hit_cnt && widx == j)
               cnt[j] <= cnt_wr[15:0];
            else if (capture_req[j])
               cnt[j] <= cnt[1];
            else if (step[j])
               cnt[j] <= next_step[j*16 +: 16];
         end
         // core one: aux a reload has priority over aux b
         if (bus_wr && hit_cnt && widx == 3'h1)
            cnt[1] <= cnt_wr[15:0];
         else if (reload_req[0])
            cnt[1] <= cnt[0];
         else if (reload_req[2])
            cnt[1] <= cnt[2];
         else if (step[1])
            cnt[1] <= next_step[31:16];
         // aux c with capture and optional clear
         // capture and clear share one edge, the old count is captured
         if (bus_wr && hit_cnt && widx == 3'h3)
            cnt[3] <= cnt_wr[15:0];
         else if (cap_hit && ctrl[3][`DMT_F_CLEAR_CAP])
            cnt[3] <= 16'h0000;
         else if (step[3])
            cnt[3] <= next_step[63:48];
         // core two, reload from capture register on wrap
         // a wrap with reload set loads instead of rolling over
         if (bus_wr && hit_cnt && widx == 3'h4)
            cnt[4] <= cnt_wr[15:0];
         else if (wrap[4] && ctrl[4][`DMT_F_CAP_RELOAD])
            cnt[4] <= capture_reload_register;
         else if (step[4])
            cnt[4] <= next_step[79:64];
         // capture register
         if (bus_wr && hit_cap)
            capture_reload_register <= cap_wr[15:0];
         else if (cap_hit)
            capture_reload_register <= cnt[3];
      end
   end

   // toggle latches, pins, wrap pulse and sticky flags
   // pins follow the latches one cycle late, like every output
   // the wrap pulse also clocks the external compare unit
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         core_one_toggle_latch <= 1'b0;
         core_two_toggle_latch <= 1'b0;
         one_latch_old         <= 1'b0;
         two_latch_old         <= 1'b0;
         core_one_latch_pin    <= 1'b0;
         core_two_latch_pin    <= 1'b0;
         core_two_wrap_pulse   <= 1'b0;
         flags                 <= 6'h00;
      end
      else
      begin
         if (wrap[1])
            core_one_toggle_latch <= ~core_one_toggle_latch;
         if (wrap[4])
            core_two_toggle_latch <= ~core_two_toggle_latch;
         one_latch_old       <= core_one_toggle_latch;
         two_latch_old       <= core_two_toggle_latch;
         core_one_latch_pin  <= core_one_toggle_latch;
         core_two_latch_pin  <= core_two_toggle_latch;
         core_two_wrap_pulse <= wrap[4];
         // flags: bit 5 capture, bits 4 to 0 wrap per timer
         // write one clears, a new event in the same cycle wins
         flags <= (flags & ~((bus_wr && hit_stat) ? wb_dat_i[5:0] : 6'h00)) |
                  {cap_hit, wrap};
      end
   end

endmodule
`default_nettype wire

/* File: sim/dmt_timer_unit_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// port checks on bus handshake, latch pins and wrap pulse
module dmt_timer_unit_checker
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        core_one_latch_pin,
   input wire logic        core_two_latch_pin,
   input wire logic        core_two_wrap_pulse
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // a request not yet answered
   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   a_bus_answer: assert property (req |=> wb_ack_o) else $error("no ack after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
   a_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i >= 8'h48 |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_reset_quiet: assert property ($rose(rst_n) |-> !(wb_ack_o || core_one_latch_pin || core_two_latch_pin))
      else $error("output active after reset");
   a_core_one_rate: assert property ($changed(core_one_latch_pin) |=> $stable(core_one_latch_pin)[*3])
      else $error("core one latch toggles too fast");
   a_core_two_rate: assert property ($changed(core_two_latch_pin) |=> $stable(core_two_latch_pin))
      else $error("core two latch toggles too fast");
   a_wrap_single: assert property (core_two_wrap_pulse |=> !core_two_wrap_pulse)
      else $error("wrap pulse longer than one cycle");
   a_wrap_toggles: assert property ($rose(core_two_wrap_pulse) |-> ##[0:1] $changed(core_two_latch_pin))
      else $error("wrap without latch toggle");
   c_read: cover property (req && !wb_we_i);
   c_latch_one: cover property ($changed(core_one_latch_pin));
   c_wrap: cover property (core_two_wrap_pulse);
endmodule
bind dmt_timer_unit dmt_timer_unit_checker u_chk (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .core_one_latch_pin(core_one_latch_pin), .core_two_latch_pin(core_two_latch_pin),
   .core_two_wrap_pulse(core_two_wrap_pulse));
`default_nettype wire

/* File: sim/dmt_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
// far-side pins: count edges, capture edge, quadrature tracks, direction levels
// encoder index track goes to an interrupt input, not to these pins
module dmt_pin_model
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [5:0] edge_req,
   input  wire logic       enc_step,
   input  wire logic       enc_rev,
   input  wire logic [3:0] dir_level,
   output logic      [4:0] gate_pins,
   output logic      [3:0] dir_pins,
   output logic            cap_pin
);
   logic [4:0] lvl;
   logic [1:0] phase;
   // one transition per request bit; gray phase steps for the encoder
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lvl     <= 5'h00;
         cap_pin <= 1'b0;
         phase   <= 2'h0;
      end
      else
      begin
         lvl     <= lvl ^ edge_req[4:0];
         cap_pin <= cap_pin ^ edge_req[5];
         if (enc_step)
            phase <= enc_rev ? phase - 2'h1 : phase + 2'h1;
      end
   end
   // track a on aux b gate pin, track b on its direction pin
   // tracks ride on the plain levels, so counter tests still see their edges
   always @*
   begin
      gate_pins    = lvl;
      gate_pins[2] = lvl[2] ^ phase[1];
      dir_pins     = dir_level;
      dir_pins[2]  = dir_level[2] ^ phase[1] ^ phase[0];
   end
endmodule
`default_nettype wire

/* File: sim/dmt_timer_unit_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dmt_consts.vh"
module dmt_timer_unit_tb;
   logic        clk, rst_n, wb_cyc, wb_stb, wb_we, ack, cap, lat1, lat2, wrap;
   logic        down, enc_step, enc_rev;
   logic [7:0]  wb_adr;
   logic [31:0] wb_dat, rd_dat, lo_v, hi_v, ctrl;
   logic [4:0]  gate;
   logic [3:0]  dir, dir_level;
   logic [5:0]  edge_req;
   logic [63:0] exp_q[$];
   int          failures, num_checks, seed, t, wraps;
   dmt_timer_unit u_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(rd_dat), .wb_ack_o(ack),
      .timer_gate_count_input(gate), .timer_direction_input(dir), .capture_trigger_pin(cap),
      .core_one_latch_pin(lat1), .core_two_latch_pin(lat2), .core_two_wrap_pulse(wrap));
   dmt_pin_model u_pins (.clk(clk), .rst_n(rst_n), .edge_req(edge_req), .enc_step(enc_step),
      .enc_rev(enc_rev), .dir_level(dir_level), .gate_pins(gate), .dir_pins(dir), .cap_pin(cap));
   always #2.5 clk = ~clk;
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // one classic cycle; a read leaves its accepted range as a note
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, lo, hi);
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= we;
      wb_adr <= a;
      wb_dat <= d;
      if (!we)
         exp_q.push_back({lo, hi});
      @(posedge clk);
      while (ack !== 1'b1)
         @(posedge clk);
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask
   task automatic pulse(input logic [5:0] m, input int k);
      repeat (k)
      begin
         @(posedge clk);
         edge_req <= m;
         @(posedge clk);
         edge_req <= 6'h00;
         repeat (8) @(posedge clk);
      end
   endtask
   task automatic step(input logic rev, input int k);
      repeat (k)
      begin
         @(posedge clk);
         enc_step <= 1'b1;
         enc_rev  <= rev;
         @(posedge clk);
         enc_step <= 1'b0;
         repeat (8) @(posedge clk);
      end
   endtask
   // compare each read answer with the oldest note
   always @(posedge clk)
   begin
      if (ack === 1'b1 && wb_we === 1'b0)
      begin
         {lo_v, hi_v} = exp_q.pop_front();
         check("read data", rd_dat, ((^rd_dat) !== 1'bx && rd_dat >= lo_v && rd_dat <= hi_v) ? rd_dat : lo_v);
      end
   end
   // count wrap pulses sent to the compare unit
   always @(posedge clk)
   begin
      if (wrap === 1'b1)
         wraps++;
   end
   // watchdog against a hung handshake
   initial
   begin
      repeat (20000) @(posedge clk);
      failures++;
      finish_test();
   end
   initial
   begin
      {clk, rst_n, wb_cyc, wb_stb, wb_we, enc_step, enc_rev} = 7'h00;
      {wb_adr, wb_dat, edge_req, dir_level} = 0;
      seed = 32'hee838ee9;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, `DMT_OFS_CTRL0, 0, 0, 0);
      bus(1'b0, `DMT_OFS_STATUS, 0, 0, 0);
      bus(1'b1, 8'h80, 32'hffffffff, 0, 0);
      bus(1'b0, 8'h80, 0, 0, 0);
      // counter mode on every timer, direction by pin or by software
      for (t = 0; t < 5; t++)
      begin
         down = 1'($random(seed));
         dir_level <= {4{down}};
         ctrl = (t == 3) ? (32'h60a | {27'h0, down, 4'h0}) : 32'h62a;
         bus(1'b1, `DMT_OFS_CNT0 + 8'(4 * t), 32'd100, 0, 0);
         bus(1'b1, `DMT_OFS_CTRL0 + 8'(4 * t), ctrl, 0, 0);
         bus(1'b0, `DMT_OFS_CTRL0 + 8'(4 * t), 0, ctrl, ctrl);
         pulse(6'(1 << t), 3);
         bus(1'b1, `DMT_OFS_CTRL0 + 8'(4 * t), 0, 0, 0);
         ctrl = down ? 32'd97 : 32'd103;
         bus(1'b0, `DMT_OFS_CNT0 + 8'(4 * t), 0, ctrl, ctrl);
      end
      // core timers at the base rate, no prescale, wrapping from the top
      bus(1'b1, `DMT_OFS_CNT0 + 8'h04, 32'hffff, 0, 0);
      bus(1'b1, `DMT_OFS_CNT0 + 8'h10, 32'hffff, 0, 0);
      bus(1'b1, `DMT_OFS_CTRL0 + 8'h04, 32'h8, 0, 0);
      bus(1'b1, `DMT_OFS_CTRL0 + 8'h10, 32'h8, 0, 0);
      repeat (40) @(posedge clk);
      bus(1'b1, `DMT_OFS_CTRL0 + 8'h04, 0, 0, 0);
      bus(1'b1, `DMT_OFS_CTRL0 + 8'h10, 0, 0, 0);
      check("core one latch", {31'h0, lat1}, 32'h1);
      check("core two latch", {31'h0, lat2}, 32'h1);
      bus(1'b0, `DMT_OFS_CNT0 + 8'h04, 0, 32'd8, 32'd11);
      bus(1'b0, `DMT_OFS_CNT0 + 8'h10, 0, 32'd19, 32'd22);
      bus(1'b0, `DMT_OFS_STATUS, 0, 32'h12, 32'h12);
      bus(1'b1, `DMT_OFS_STATUS, 32'h12, 0, 0);
      bus(1'b0, `DMT_OFS_STATUS, 0, 0, 0);
      // quadrature steps forward then back; gate left high, so forward counts up
      dir_level <= 4'h0;
      bus(1'b1, `DMT_OFS_CNT0 + 8'h08, 32'd100, 0, 0);
      bus(1'b1, `DMT_OFS_CTRL0 + 8'h08, 32'hb, 0, 0);
      step(1'b0, 4);
      bus(1'b0, `DMT_OFS_CNT0 + 8'h08, 0, 32'd104, 32'd104);
      step(1'b1, 4);
      bus(1'b0, `DMT_OFS_CNT0 + 8'h08, 0, 32'd100, 32'd100);
      // aux a reloads core one, aux b captures it; both stay stopped
      bus(1'b1, `DMT_OFS_CNT0, 32'd500, 0, 0);
      bus(1'b1, `DMT_OFS_CTRL0, 32'h605, 0, 0);
      bus(1'b1, `DMT_OFS_CTRL0 + 8'h08, 32'h606, 0, 0);
      pulse(6'h01, 1);
      pulse(6'h04, 1);
      bus(1'b0, `DMT_OFS_CNT0 + 8'h04, 0, 32'd500, 32'd500);
      bus(1'b0, `DMT_OFS_CNT0 + 8'h08, 0, 32'd500, 32'd500);
      bus(1'b0, `DMT_OFS_CNT0, 0, 32'd500, 32'd500);
      // capture of aux c by its pin, then by the core one count pin
      bus(1'b1, `DMT_OFS_CNT0 + 8'h0c, 0, 0, 0);
      bus(1'b1, `DMT_OFS_CTRL0 + 8'h0c, 32'h860a, 0, 0);
      pulse(6'h08, 5);
      pulse(6'h20, 1);
      bus(1'b0, `DMT_OFS_CAPTURE_RELOAD_REGISTER, 0, 32'd5, 32'd5);
      bus(1'b0, `DMT_OFS_CNT0 + 8'h0c, 0, 0, 0);
      bus(1'b0, `DMT_OFS_STATUS, 0, 32'h20, 32'h20);
      bus(1'b1, `DMT_OFS_CTRL0 + 8'h0c, 32'h1860a, 0, 0);
      pulse(6'h08, 2);
      pulse(6'h02, 1);
      bus(1'b0, `DMT_OFS_CAPTURE_RELOAD_REGISTER, 0, 32'd2, 32'd2);
      repeat (4) @(posedge clk);
      check("wrap pulses", wraps, 32'd1);
      finish_test();
   end
endmodule
`default_nettype wire
